/* design/cpsw_ctl.sv */
// Purpose: Link controller issuing one switch write per software order
// Assumes: Single-cycle register strobes, read data one cycle later
// Notes: Generates the serial clock by division of the system clock
`timescale 1ns/1ps
module cpsw_ctl #(
  parameter int HALF_CYC = cpsw_pkg::SCL_HALF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  cpsw_link_if.ctl link,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  typedef enum logic [2:0] {
    CPSW_C_IDLE = 3'b000,
    CPSW_C_START = 3'b001,
    CPSW_C_BIT = 3'b010,
    CPSW_C_ACK = 3'b011,
    CPSW_C_STOP = 3'b100
  } cpsw_cstate_t;
  cpsw_cstate_t st_r;
  logic [2:0] target_r;
  logic rst_n_r;
  logic busy_r, nack_r;
  logic [23:0] word_r;
  logic [4:0] bit_r;
  logic [1:0] phase_r;
  logic [7:0] div_r;
  logic [1:0] sda_s_r;
  wire tick = (div_r == 8'(HALF_CYC - 1));
  wire go = i_wr && (i_addr == cpsw_pkg::REG_CMD) && !busy_r;
  // Read decode; unmapped addresses read zero
  wire [31:0] rd_mux = (i_addr == cpsw_pkg::REG_STATUS) ?
                       {29'h0, rst_n_r, nack_r, busy_r} :
                       (i_addr == cpsw_pkg::REG_TARGET) ? {28'h0, rst_n_r, target_r} : 32'h0;
  // Register writes; a command while busy is ignored
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      target_r <= cpsw_pkg::TARGET_RESET;
      rst_n_r <= 1'b1;
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
      if (i_wr && i_addr == cpsw_pkg::REG_TARGET) begin
        target_r <= i_wdata[2:0];
        if (!busy_r) rst_n_r <= i_wdata[3];
      end
    end
  end
  // ----------------------------------------
  // Serial engine: phase 0 low, 1 rise, 2 high, 3 fall
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r <= CPSW_C_IDLE;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      word_r <= 24'h0;
      bit_r <= 5'h0;
      phase_r <= 2'h0;
      div_r <= 8'h0;
      sda_s_r <= 2'h3;
      link.scl <= 1'b1;
      link.ctl_sda_o <= 1'b1;
      link.ctl_sda_oe_n <= 1'b1;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
      div_r <= (tick || st_r == CPSW_C_IDLE) ? 8'h0 : div_r + 8'h1;
      case (st_r)
        CPSW_C_IDLE: begin
          if (go) begin
            // Address byte, direction write, then two data bytes
            word_r <= {cpsw_pkg::ADDR_FIXED, target_r, cpsw_pkg::RW_WRITE, i_wdata[15:0]};
            busy_r <= 1'b1;
            nack_r <= 1'b0;
            bit_r <= 5'h0;
            phase_r <= 2'h0;
            link.ctl_sda_o <= 1'b0;
            link.ctl_sda_oe_n <= 1'b0;
            st_r <= CPSW_C_START;
          end
        end
        CPSW_C_START: if (tick) begin
          link.scl <= 1'b0;
          st_r <= CPSW_C_BIT;
        end
        CPSW_C_BIT: if (tick) begin
          phase_r <= phase_r + 2'h1;
          if (phase_r == 2'h0) begin
            link.ctl_sda_o <= word_r[23];
            link.ctl_sda_oe_n <= word_r[23];
          end else if (phase_r == 2'h1) begin
            link.scl <= 1'b1;
          end else if (phase_r == 2'h3) begin
            link.scl <= 1'b0;
            word_r <= {word_r[22:0], 1'b0};
            bit_r <= bit_r + 5'h1;
            if (bit_r[2:0] == 3'h7) begin
              st_r <= CPSW_C_ACK;
            end
          end
        end
        CPSW_C_ACK: if (tick) begin
          phase_r <= phase_r + 2'h1;
          if (phase_r == 2'h0) begin
            link.ctl_sda_o <= 1'b1;
            link.ctl_sda_oe_n <= 1'b1;
          end else if (phase_r == 2'h1) begin
            link.scl <= 1'b1;
          end else if (phase_r == 2'h2) begin
            nack_r <= nack_r | sda_s_r[1];
          end else begin
            link.scl <= 1'b0;
            st_r <= (bit_r == 5'd24 || sda_s_r[1]) ? CPSW_C_STOP : CPSW_C_BIT;
          end
        end
        CPSW_C_STOP: if (tick) begin
          phase_r <= phase_r + 2'h1;
          if (phase_r == 2'h0) begin
            link.ctl_sda_o <= 1'b0;
            link.ctl_sda_oe_n <= 1'b0;
          end else if (phase_r == 2'h1) begin
            link.scl <= 1'b1;
          end else if (phase_r == 2'h2) begin
            link.ctl_sda_o <= 1'b1;
            link.ctl_sda_oe_n <= 1'b1;
          end else begin
            busy_r <= 1'b0;
            st_r <= CPSW_C_IDLE;
          end
        end
        default: st_r <= CPSW_C_IDLE;
      endcase
    end
  end
  assign link.rst_n = rst_n_r;
endmodule : cpsw_ctl

/* design/cpsw_device.sv */
// Purpose: Serial write receiver and 8 by 12 switch state array
// Assumes: Serial clock and data are sampled by the system clock
// Notes: Readback is not provided; read-direction frames are not acknowledged
`timescale 1ns/1ps
module cpsw_device #(
  parameter int NX = cpsw_pkg::NUM_X,
  parameter int NY = cpsw_pkg::NUM_Y
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  cpsw_link_if.dev link,
  input wire logic i_addr_pin_bit0,
  input wire logic i_addr_pin_bit1,
  input wire logic i_addr_pin_bit2,
  output logic [NX*NY-1:0] o_switch_on,
  output logic o_cmd_done
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] scl_s_r, sda_s_r, rstn_s_r, ap0_s_r, ap1_s_r, ap2_s_r;
  logic scl_d_r, sda_d_r;
  // Two flops per outside level, a third on clock and data for edges; the first stage is never read
  always_ff @(posedge i_sys_clk) begin
    scl_s_r <= {scl_s_r[0], link.scl};
    sda_s_r <= {sda_s_r[0], link.sda};
    rstn_s_r <= {rstn_s_r[0], link.rst_n};
    ap0_s_r <= {ap0_s_r[0], i_addr_pin_bit0};
    ap1_s_r <= {ap1_s_r[0], i_addr_pin_bit1};
    ap2_s_r <= {ap2_s_r[0], i_addr_pin_bit2};
    scl_d_r <= scl_s_r[1];
    sda_d_r <= sda_s_r[1];
  end
  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire pin_rst = ~rstn_s_r[1];
  wire clr = i_rst | pin_rst;
  wire scl_rise = scl & ~scl_d_r;
  wire scl_fall = ~scl & scl_d_r;
  wire start_c = scl & scl_d_r & sda_d_r & ~sda;
  wire stop_c = scl & scl_d_r & ~sda_d_r & sda;
  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  typedef enum logic [2:0] {
    CPSW_IDLE = 3'b000,
    CPSW_BITS = 3'b001,
    CPSW_ACK = 3'b010,
    CPSW_IGNORE = 3'b011,
    CPSW_DONE = 3'b100
  } cpsw_state_t;
  cpsw_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_cnt_r, byte_cnt_nxt;
  logic [23:0] shift_r, shift_nxt; // switch_command_shift
  logic ack_drv_r, ack_drv_nxt;
  logic [NX*NY-1:0] latch_r, latch_nxt, live_r, live_nxt;
  logic done_r, done_nxt;
  wire [2:0] addr_pins = {ap2_s_r[1], ap1_s_r[1], ap0_s_r[1]};
  wire [6:0] own_addr = {cpsw_pkg::ADDR_FIXED, addr_pins};
  wire [7:0] addr_byte = shift_r[7:0];
  wire addr_hit = (addr_byte[7:1] == own_addr) && (addr_byte[0] == cpsw_pkg::RW_WRITE);
  wire [15:0] data_w = shift_r[15:0];
  wire [3:0] x_code = data_w[cpsw_pkg::X_MSB:cpsw_pkg::X_LSB];
  wire [2:0] y_sel = data_w[cpsw_pkg::Y_MSB:cpsw_pkg::Y_LSB];
  wire x_ok = cpsw_pkg::x_code_valid(x_code);
  wire [3:0] x_line = cpsw_pkg::x_code_line(x_code);
  wire new_state = data_w[cpsw_pkg::STATE_BIT];
  wire upd = data_w[cpsw_pkg::UPD_BIT];
  wire [6:0] sw_idx = 7'(y_sel * NX) + 7'(x_line);
  // Next-state logic for the receiver and the two switch stages
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    shift_nxt = shift_r;
    ack_drv_nxt = ack_drv_r;
    latch_nxt = latch_r;
    live_nxt = live_r;
    done_nxt = 1'b0;
    case (state_r)
      CPSW_IDLE: begin
      end
      CPSW_BITS: begin
        if (scl_rise) begin
          shift_nxt = {shift_r[22:0], sda};
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        if (scl_fall && bit_cnt_r == cpsw_pkg::BITS_PER_BYTE) begin
          byte_cnt_nxt = byte_cnt_r + 2'h1;
          bit_cnt_nxt = 4'h0;
          if (byte_cnt_r == 2'h0 && !addr_hit) begin
            state_nxt = CPSW_IGNORE;
          end else begin
            ack_drv_nxt = 1'b1;
            state_nxt = CPSW_ACK;
          end
        end
      end
      CPSW_ACK: begin
        if (scl_fall) begin
          ack_drv_nxt = 1'b0;
          state_nxt = (byte_cnt_r == cpsw_pkg::BYTES_PER_CMD) ? CPSW_DONE : CPSW_BITS;
        end
      end
      CPSW_DONE: begin
        // Apply once all three bytes are in; further bytes are refused
        if (x_ok) begin
          latch_nxt[sw_idx] = new_state;
          if (upd) begin
            live_nxt = latch_nxt;
          end
        end
        done_nxt = 1'b1;
        state_nxt = CPSW_IGNORE;
      end
      default: begin
      end
    endcase
    // Start wins from any state; stop abandons a partial frame
    if (start_c) begin
      state_nxt = CPSW_BITS;
      bit_cnt_nxt = 4'h0;
      byte_cnt_nxt = 2'h0;
      ack_drv_nxt = 1'b0;
    end else if (stop_c) begin
      state_nxt = CPSW_IDLE;
      ack_drv_nxt = 1'b0;
    end
  end
  // State registers; reset pin and system reset clear everything
  always_ff @(posedge i_sys_clk) begin
    if (clr) begin
      state_r <= CPSW_IDLE;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 2'h0;
      shift_r <= 24'h000000;
      ack_drv_r <= 1'b0;
      latch_r <= '0;
      live_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r <= shift_nxt;
      ack_drv_r <= ack_drv_nxt;
      latch_r <= latch_nxt;
      live_r <= live_nxt;
      done_r <= done_nxt;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ack drives low; the enable is active low while driving
  // Taken from the next value so the ack settles before a fast clock rises
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      link.dev_sda_o <= 1'b1;
      link.dev_sda_oe_n <= 1'b1;
    end else begin
      link.dev_sda_o <= 1'b0;
      link.dev_sda_oe_n <= ~(ack_drv_nxt & ~clr);
    end
  end
  assign o_switch_on = live_r;
  assign o_cmd_done = done_r;
endmodule : cpsw_device

/* pkg/cpsw_link_if.sv */
// Purpose: Two-wire link between controller and switch device
// Assumes: Open-drain data line, enables are active low
// Notes: Wire levels are resolved here from both ends' enables
`timescale 1ns/1ps
interface cpsw_link_if;
  logic scl;
  logic rst_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;
  // Wired-AND with pull-up: any enabled driver low pulls the line low
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport ctl (output scl, output rst_n, output ctl_sda_o, output ctl_sda_oe_n, input sda);
  modport dev (input scl, input rst_n, output dev_sda_o, output dev_sda_oe_n, input sda);
endinterface : cpsw_link_if

/* pkg/cpsw_pkg.sv */
// Purpose: Shared constants for the crosspoint switch write link
// Assumes: Two-wire serial link, controller drives the serial clock
// Notes: Bit positions refer to the 16 data bits after the address byte
package cpsw_pkg;
  // ----------------------------------------
  // Array shape and addressing
  // ----------------------------------------
  localparam int NUM_X = 12;
  localparam int NUM_Y = 8;
  localparam int NUM_SW = 96;
  localparam logic [3:0] ADDR_FIXED = 4'hE;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // ----------------------------------------
  // Data word field positions
  // ----------------------------------------
  localparam int STATE_BIT = 15;
  localparam int X_MSB = 14;
  localparam int X_LSB = 11;
  localparam int Y_MSB = 10;
  localparam int Y_LSB = 8;
  localparam int UPD_BIT = 0;
  localparam logic [3:0] X_HALF_BASE = 4'h8;
  localparam logic [3:0] X_HALF_LIMIT = 4'h5;
  localparam logic [3:0] X_UPPER_OFS = 4'h6;
  // ----------------------------------------
  // Frame counts
  // ----------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] BYTES_PER_CMD = 2'h3;
  // Controller clock divider: quarter-period of the serial clock in system cycles
  localparam int SCL_HALF_NS = 2000;
  localparam int SYS_CLK_NS = 40;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / SYS_CLK_NS;
  // ----------------------------------------
  // Controller register map
  // ----------------------------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TARGET = 4'h8;
  localparam logic [2:0] TARGET_RESET = 3'h0;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_RST_N = 2;
  // X field decode: codes 0..5 and 8..13 map to lines 0..11, others invalid
  function automatic logic x_code_valid(input logic [3:0] code);
    return (code <= X_HALF_LIMIT) || ((code >= X_HALF_BASE) && (code <= X_HALF_BASE + X_HALF_LIMIT));
  endfunction : x_code_valid
  function automatic logic [3:0] x_code_line(input logic [3:0] code);
    return code[3] ? (code - X_HALF_BASE + X_UPPER_OFS) : code;
  endfunction : x_code_line
endpackage : cpsw_pkg

/* sim/cpsw_link_chk.sv */
// Purpose: Wire checks on the link joining controller and switch device
// Assumes: Controller half phase of 8 system cycles
// Notes: Bit positions are counted from the last start condition
`timescale 1ns/1ps
module cpsw_link_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic rst_n,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  // ----------------------------------------
  // Frame position tracking
  // ----------------------------------------
  logic [4:0] rise_r;
  logic scl_r;
  logic sda_r;
  // Rises since start; saturates so a runaway frame cannot wrap into a legal count
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rise_r <= 5'h00;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (scl && scl_r && sda_r && !sda) begin
        rise_r <= 5'h00;
      end else if (scl && !scl_r && rise_r != 5'h1F) begin
        rise_r <= rise_r + 5'h01;
      end
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence rise_s; $rose(scl); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  sequence ack_on_s; $fell(dev_sda_oe_n); endsequence
  // Acknowledge must hold for the first 8 cycles of the high phase so the controller samples it
  rst_hold_a: assert property (!ctl_sda_oe_n |-> rst_n) else $error("reset low while controller drives");
  dev_drain_a: assert property (!dev_sda_oe_n |-> !dev_sda_o) else $error("device drives data high");
  ack_start_a: assert property (ack_on_s |-> !scl) else $error("acknowledge begun with clock high");
  ack_hold_a: assert property (rise_s ##0 !dev_sda_oe_n |-> (!dev_sda_oe_n) [*8]) else $error("ack dropped");
  ack_pos_a: assert property (ack_on_s |-> rise_r % 9 == 8) else $error("acknowledge off the ninth bit");
  addr_fixed_a: assert property (rise_s ##0 rise_r < 4 |-> sda == cpsw_pkg::ADDR_FIXED[3 - rise_r[1:0]])
    else $error("fixed address bits wrong");
  write_dir_a: assert property (rise_s ##0 rise_r == 7 |-> sda == cpsw_pkg::RW_WRITE) else $error("not a write");
  // The stop condition's own clock rise is counted too
  frame_len_a: assert property (stop_s |-> rise_r == 10 || rise_r == 28) else $error("frame length wrong");
endmodule : cpsw_link_chk

/* sim/crosspoint_switch_write_decoder_test.sv */
// Purpose: Self-checking bench for controller and switch device together
// Assumes: Half phase shortened to 8 cycles; second link bit-banged by the bench
// Notes: Switch model is two bit vectors, live and held
`timescale 1ns/1ps
module crosspoint_switch_write_decoder_test;
  localparam int HC = 8;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [31:0] q;
  logic [2:0] pins = 3'h0;
  logic [2:0] ak;
  logic [95:0] sw_a, sw_b, m_live, m_held;
  logic done_a, done_b;
  int num_errors = 0, check_count = 0, done_cnt = 0, done_cnt_b = 0, exp_done = 0;
  cpsw_link_if link_a ();
  cpsw_link_if link_b ();
  always #20 i_sys_clk = ~i_sys_clk;
  cpsw_ctl #(.HALF_CYC(HC)) cpsw_ctl_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_a.ctl), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  cpsw_device cpsw_device_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_a.dev), .i_addr_pin_bit0(pins[0]),
    .i_addr_pin_bit1(pins[1]), .i_addr_pin_bit2(pins[2]), .o_switch_on(sw_a), .o_cmd_done(done_a));
  cpsw_device cpsw_device_i2 (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .link(link_b.dev), .i_addr_pin_bit0(pins[0]),
    .i_addr_pin_bit1(pins[1]), .i_addr_pin_bit2(pins[2]), .o_switch_on(sw_b), .o_cmd_done(done_b));
  cpsw_link_chk cpsw_link_chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .scl(link_a.scl), .rst_n(link_a.rst_n),
    .ctl_sda_o(link_a.ctl_sda_o), .ctl_sda_oe_n(link_a.ctl_sda_oe_n), .dev_sda_o(link_a.dev_sda_o),
    .dev_sda_oe_n(link_a.dev_sda_oe_n), .sda(link_a.sda));
  // Done pulses stand one cycle, so they are counted at every edge
  always @(posedge i_sys_clk) begin
    if (done_a === 1'b1) done_cnt++;
    if (done_b === 1'b1) done_cnt_b++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask : rd
  // Issue one command; dup adds a second order while busy, which must be refused
  task automatic send(input logic [15:0] c, input bit ok, input bit dup);
    int n;
    bit seen;
    int xl;
    seen = 0;
    wr(cpsw_pkg::REG_CMD, {16'h0000, c});
    if (dup) wr(cpsw_pkg::REG_CMD, {16'h0000, ~c});
    for (n = 0; n < 3000 && !(seen && q[cpsw_pkg::ST_BUSY] === 1'b0); n++) begin
      rd(cpsw_pkg::REG_STATUS);
      if (q[cpsw_pkg::ST_BUSY] === 1'b1) seen = 1;
    end
    if (n == 3000) begin
      num_errors++;
      stop_test();
    end
    xl = (c[14:11] >= 4'h8) ? int'(c[14:11]) - 2 : int'(c[14:11]);
    if (ok) begin
      exp_done++;
      if (c[14:11] <= 4'h5 || (c[14:11] >= 4'h8 && c[14:11] <= 4'hD)) begin
        m_held[int'(c[10:8]) * 12 + xl] = c[15];
        if (c[0]) m_live = m_held;
      end
    end
    repeat (4) @(posedge i_sys_clk);
    chk("switches", m_live, sw_a);
    chk("done count", 96'(exp_done), 96'(done_cnt));
  endtask : send
  // Bench-made link clock, 320 ns period, still between frames
  task automatic bb_frame(input logic [23:0] w, input int nb);
    int i;
    @(posedge i_sys_clk);
    link_b.ctl_sda_oe_n <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    link_b.scl <= 1'b0;
    for (i = 0; i < nb * 9; i++) begin
      repeat (2) @(posedge i_sys_clk);
      link_b.ctl_sda_oe_n <= (i % 9 == 8) ? 1'b1 : w[23 - (i / 9) * 8 - i % 9];
      repeat (2) @(posedge i_sys_clk);
      link_b.scl <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      if (i % 9 == 8) ak[i / 9] = link_b.sda;
      repeat (2) @(posedge i_sys_clk);
      link_b.scl <= 1'b0;
    end
    repeat (2) @(posedge i_sys_clk);
    link_b.ctl_sda_oe_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    link_b.scl <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    link_b.ctl_sda_oe_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
  endtask : bb_frame
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    link_b.scl = 1'b1;
    link_b.rst_n = 1'b1;
    link_b.ctl_sda_o = 1'b0;
    link_b.ctl_sda_oe_n = 1'b1;
    m_live = '0;
    m_held = '0;
    void'($urandom(32));
    pins <= 3'($urandom);
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(cpsw_pkg::REG_STATUS);
    chk("status after reset", 96'h4, 96'(q));
    chk("switches after reset", '0, sw_a);
    rd(4'hC);
    chk("unmapped read", '0, 96'(q));
    wr(cpsw_pkg::REG_TARGET, {28'h0, 1'b1, pins});
    rd(cpsw_pkg::REG_TARGET);
    chk("target", 96'({1'b1, pins}), 96'(q));
    for (int x = 0; x < 16; x++) send({1'b1, 4'(x), 3'(x), 7'($urandom), 1'b1}, 1, 0);
    for (int k = 0; k < 16; k++) send(16'($urandom), 1, k == 3);
    send({1'b1, 4'h3, 3'h5, 8'h00}, 1, 0);
    send({1'b1, 4'hD, 3'h7, 8'h01}, 1, 0);
    wr(cpsw_pkg::REG_TARGET, {28'h0, 1'b1, pins ^ 3'h1});
    send(16'h8001, 0, 0);
    chk("nack flag", 96'h1, 96'(q[cpsw_pkg::ST_NACK]));
    wr(cpsw_pkg::REG_TARGET, {28'h0, 1'b1, pins});
    send({1'b1, 4'h2, 3'h3, 8'h00}, 1, 0);
    wr(cpsw_pkg::REG_TARGET, {28'h0, 1'b0, pins});
    repeat (8) @(posedge i_sys_clk);
    m_live = '0;
    m_held = '0;
    chk("switches in pin reset", m_live, sw_a);
    wr(cpsw_pkg::REG_TARGET, {28'h0, 1'b1, pins});
    send({1'b1, 4'h9, 3'h6, 8'h01}, 1, 0);
    bb_frame({cpsw_pkg::ADDR_FIXED, pins, cpsw_pkg::RW_READ, 16'h8001}, 1);
    chk("read frame ack", 96'h1, 96'(ak[0]));
    bb_frame({cpsw_pkg::ADDR_FIXED, pins, cpsw_pkg::RW_WRITE, 16'h8001}, 2);
    chk("short frame acks", 96'h0, 96'(ak[1:0]));
    chk("short frame switches", '0, sw_b);
    chk("short frame done", 96'h0, 96'(done_cnt_b));
    bb_frame({cpsw_pkg::ADDR_FIXED, pins, cpsw_pkg::RW_WRITE, 16'hE901}, 3);
    chk("full frame acks", 96'h0, 96'(ak));
    chk("full frame switches", 96'h1 << 23, sw_b);
    chk("full frame done", 96'h1, 96'(done_cnt_b));
    stop_test();
  end
endmodule : crosspoint_switch_write_decoder_test
